// *** dv/block_window_access_engine_tb.sv ***
`timescale 1ns/100ps
module block_window_access_engine_tb;
   import bwin_pkg::*;
   logic              clk_i;
   logic              resetn_i;
   logic              ce_i;
   logic [ADDR_W-1:0] paddr_i;
   logic              psel_i;
   logic              penable_i;
   logic              pwrite_i;
   logic [DATA_W-1:0] pwdata_i;
   logic [DATA_W-1:0] prdata_o;
   logic              pready_o;
   logic              pslverr_o;
   logic              irq_o;
   logic [DATA_W:0]   exp_q[$];
   logic [DATA_W-1:0] mem[16];
   logic [31:0]       rng = 32'hef73;
   logic [31:0]       r;
   logic [ADDR_W-1:0] aper;
   logic [ADDR_W-1:0] regs[5];
   int                err_count = 0;
   int                checks_done = 0;

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   block_window_access_engine DUT (.clk_i, .resetn_i, .ce_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
                                   .prdata_o, .pready_o, .pslverr_o, .irq_o);
   host_driver_model host (.clk_i(clk_i), .pready_i(pready_o), .paddr_o(paddr_i), .psel_o(psel_i),
                           .penable_o(penable_i), .pwrite_o(pwrite_i), .pwdata_o(pwdata_i));

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic chk(input logic [DATA_W:0] seen, input logic [DATA_W:0] want);
      checks_done++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Expectation noted before the cycle starts
   task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d,
                      input logic [DATA_W:0] want);
      bit ok;
      exp_q.push_back(want);
      host.xfer(a, w, d, ok);
      if (!ok) begin
         err_count++;
         complete_run();
      end
   endtask

   // Interrupt output lags status by a cycle
   task automatic irq_is(input logic v);
      repeat (3) @(posedge clk_i);
      chk({32'h0, irq_o}, {32'h0, v});
   endtask

   always @(posedge clk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1) begin
         if (exp_q.size() > 0) chk({pslverr_o, prdata_o}, exp_q.pop_front());
         else err_count++;
      end
   end

   initial begin
      resetn_i = 1'b0;
      ce_i     = 1'b1;
      aper     = {APER_PAGE, 8'h00};
      regs     = '{OFF_CMD_ADDR, OFF_CMD_CTRL, OFF_STATUS, OFF_INT_STAT, OFF_INT_MASK};
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      foreach (regs[i]) bus(regs[i], 1'b0, '0, '0);
      bus(12'h020, 1'b0, '0, {1'b1, 32'h0});
      bus(12'h020, 1'b1, 32'h5a, {1'b1, 32'h0});
      irq_is(1'b0);
      $display("Test reset and map done");
      // Idle clock-enable stalls must not disturb state
      repeat (8) begin
         @(posedge clk_i);
         r = xs();
         ce_i <= r[0];
      end
      @(posedge clk_i);
      ce_i <= 1'b1;
      bus(OFF_CMD_ADDR, 1'b1, 32'h40, '0);
      bus(OFF_CMD_CTRL, 1'b1, 32'h11, '0);
      bus(OFF_CMD_ADDR, 1'b0, '0, {1'b0, 32'h40});
      bus(OFF_CMD_CTRL, 1'b0, '0, {1'b0, 32'h11});
      bus(OFF_FLUSH, 1'b1, xs(), '0);
      // Words 12..15 are scratch padding of a short logical block
      for (int k = 0; k < 16; k++) begin
         mem[k] = xs();
         bus(aper + 12'(4 * k), 1'b1, mem[k], '0);
      end
      // Read in write mode gives zero and flags a direction error
      bus(aper, 1'b0, '0, '0);
      bus(OFF_FLUSH, 1'b1, xs(), '0);
      bus(OFF_INT_STAT, 1'b0, '0, {1'b0, 32'h3});
      $display("Test block write done");
      bus(OFF_CMD_CTRL, 1'b1, 32'h10, '0);
      // Aperture cache eviction is host-side only
      bus(OFF_FLUSH, 1'b1, xs(), '0);
      for (int k = 0; k < 16; k++) bus(aper + 12'(4 * k), 1'b0, '0, {1'b0, mem[k]});
      bus(OFF_STATUS, 1'b0, '0, '0);
      $display("Test block read done");
      bus(aper + 12'h040, 1'b0, '0, '0);
      bus(aper, 1'b1, xs(), '0);
      bus(aper, 1'b0, '0, {1'b0, mem[0]});
      bus(OFF_STATUS, 1'b0, '0, {1'b0, 32'h3});
      irq_is(1'b0);
      bus(OFF_INT_MASK, 1'b1, 32'h1, '0);
      irq_is(1'b1);
      bus(OFF_INT_MASK, 1'b0, '0, {1'b0, 32'h1});
      bus(OFF_INT_STAT, 1'b0, '0, {1'b0, 32'h3});
      irq_is(1'b0);
      bus(OFF_CMD_ADDR, 1'b1, '0, '0);
      bus(OFF_STATUS, 1'b0, '0, '0);
      $display("Test errors and interrupt done");
      complete_run();
   end
endmodule

// *** dv/host_driver_model.sv ***
`timescale 1ns/100ps
module host_driver_model
   import bwin_pkg::*;
(
   // Clock and answer
   input  wire logic              clk_i,
   input  wire logic              pready_i,
   // Request
   output logic      [ADDR_W-1:0] paddr_o,
   output logic                   psel_o,
   output logic                   penable_o,
   output logic                   pwrite_o,
   output logic      [DATA_W-1:0] pwdata_o
);
   initial {paddr_o, psel_o, penable_o, pwrite_o, pwdata_o} = '0;
   // Held until ready; ok low on timeout
   task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d, output bit ok);
      int n;
      @(posedge clk_i);
      paddr_o  <= a;
      pwrite_o <= w;
      pwdata_o <= d;
      psel_o   <= 1'b1;
      @(posedge clk_i);
      penable_o <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 64);
      ok = pready_i === 1'b1;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      // Released data must not look valid
      pwdata_o  <= ~d;
   endtask
endmodule

// *** pkg/bwin_pkg.sv ***
package bwin_pkg;

   // Bus and media geometry
   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 32;
   localparam int MEM_AW     = 8;
   localparam int APER_IW    = 6;
   localparam int SIZE_W     = 3;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CMD_ADDR = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_CMD_CTRL = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_FLUSH    = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 12'h014;

   // Aperture occupies byte offsets 0x100..0x1ff
   localparam logic [3:0]        APER_PAGE    = 4'h1;

   // Command control fields
   localparam int                CTRL_DIR_BIT  = 0;
   localparam int                CTRL_SIZE_LSB = 4;
   localparam logic              DIR_READ      = 1'b0;
   localparam logic              DIR_WRITE     = 1'b1;
   // One 64-byte line is 16 words
   localparam int                LINE_SHIFT    = 4;

   // Window status fields
   localparam int                ST_RANGE_BIT   = 0;
   localparam int                ST_DIR_BIT     = 1;
   localparam int                ST_PENDING_BIT = 31;

   // Interrupt status fields
   localparam int                INT_W         = 2;
   localparam int                INT_ERR_BIT   = 0;
   localparam int                INT_DRAIN_BIT = 1;

   // Reset values
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [INT_W-1:0]  RST_INT  = 2'h0;
   localparam logic [SIZE_W-1:0] RST_SIZE = 3'h0;

endpackage

// *** rtl/block_window_access_engine.sv ***
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
// Contract
// (RL1) Status bit 31 is the pending indication and the device never sets it.
// (RL2) The host uses a physical block size that is a whole number of 64-byte lines.
// (RL3) A short logical block is padded by the host through a scratch buffer up to the physical size.
// (RL4) For a read the host programs address, read direction and size before touching the aperture.
// (RL5) For a write the host programs address, write direction and size before filling the aperture.
// (RL6) The host makes the command durable with a queue drain and a fence before aperture use.
// (RL7) A store of any value to the flush-hint address drains the write queue to the module.
// (RL8) On a module needing invalidation the host evicts the aperture lines before a read copy.
// (RL9) The host moves data in line-sized chunks, stepping aperture and buffer each time.
// (RL10) After a transfer the status register reports any error of that block.
// (RL11) The host drains and fences after write data before completing the write.
// (RL12) Window writes are persistent when they complete, so a block flush needs no device action.
// (RL13) Aperture word k maps to media word base plus k, in the programmed direction and within the size.
module block_window_access_engine
   import bwin_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic              ce_i,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [DATA_W-1:0] pwdata_i,
   output logic      [DATA_W-1:0] prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Interrupt
   output logic                   irq_o
);

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      return a[ADDR_W-1:2] == off[ADDR_W-1:2];
   endfunction

   logic [DATA_W-1:0] cmd_addr_r;
   logic              dir_r;
   logic [SIZE_W-1:0] size_r;
   logic [DATA_W-1:0] status_r;
   logic [INT_W-1:0]  int_stat_r;
   logic [INT_W-1:0]  int_mask_r;
   logic [INT_W-1:0]  int_ev;
   logic [DATA_W-1:0] prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic              irq_r;

   logic              acc;
   logic              acc_wr;
   logic              acc_rd;
   logic              prep;
   logic              aper_hit;
   logic              mapped;
   logic [APER_IW-1:0] aper_idx;
   logic [APER_IW:0]  blk_words;
   logic              in_range;
   logic              dir_ok;
   logic              ap_ok;
   logic              ap_err_range;
   logic              ap_err_dir;
   logic              cmd_wr;
   logic              mem_we;
   logic              mem_re;
   logic [MEM_AW-1:0] mem_addr;
   logic [DATA_W-1:0] mem_rdata;
   logic [DATA_W-1:0] rd_mux;

   // Access completes on the edge where pready is seen high
   assign acc    = ce_i & psel_i & penable_i & pready_r;
   assign acc_wr = acc & pwrite_i;
   assign acc_rd = acc & ~pwrite_i;
   assign prep   = ce_i & psel_i & penable_i & ~pready_r;

   assign aper_hit = paddr_i[ADDR_W-1:8] == APER_PAGE;
   assign mapped   = aper_hit | reg_hit(paddr_i, OFF_CMD_ADDR) | reg_hit(paddr_i, OFF_CMD_CTRL)
                     | reg_hit(paddr_i, OFF_STATUS) | reg_hit(paddr_i, OFF_FLUSH)
                     | reg_hit(paddr_i, OFF_INT_STAT) | reg_hit(paddr_i, OFF_INT_MASK);

   // Aperture window bounds and direction
   assign aper_idx     = paddr_i[APER_IW+1:2];
   assign blk_words    = {size_r, {LINE_SHIFT{1'b0}}};
   assign in_range     = {1'b0, aper_idx} < blk_words;                                   // RL13
   assign dir_ok       = pwrite_i == dir_r;                                              // RL13
   assign ap_ok        = aper_hit & in_range & dir_ok;
   assign ap_err_range = acc & aper_hit & ~in_range;
   assign ap_err_dir   = acc & aper_hit & ~dir_ok;
   assign mem_addr     = MEM_AW'(cmd_addr_r[MEM_AW+1:2] + {2'b00, aper_idx});            // RL13
   // Media word is written straight away, so no data is left deferred
   assign mem_we       = acc_wr & ap_ok & (dir_r == DIR_WRITE);                          // RL12
   // Read is launched in the setup cycle so data is ready for the answer register
   assign mem_re       = ce_i & psel_i & ~penable_i & ~pwrite_i & aper_hit;
   assign cmd_wr       = acc_wr & (reg_hit(paddr_i, OFF_CMD_ADDR) | reg_hit(paddr_i, OFF_CMD_CTRL));

   // The flush hint only raises an event: the queue is always drained on arrival
   assign int_ev[INT_DRAIN_BIT] = acc_wr & reg_hit(paddr_i, OFF_FLUSH);                  // RL7
   assign int_ev[INT_ERR_BIT]   = ap_err_range | ap_err_dir;

   media_store u_media (
      .clk_i   (clk_i),
      .resetn_i(resetn_i),
      .ce_i    (ce_i),
      .we_i    (mem_we),
      .re_i    (mem_re),
      .addr_i  (mem_addr),
      .wdata_i (pwdata_i),
      .rdata_o (mem_rdata)
   );

   always_comb begin
      rd_mux = RST_WORD;
      if (aper_hit) begin
         rd_mux = ap_ok ? mem_rdata : RST_WORD;
      end else if (reg_hit(paddr_i, OFF_CMD_ADDR)) begin
         rd_mux = cmd_addr_r;
      end else if (reg_hit(paddr_i, OFF_CMD_CTRL)) begin
         rd_mux[CTRL_DIR_BIT] = dir_r;
         rd_mux[CTRL_SIZE_LSB +: SIZE_W] = size_r;
      end else if (reg_hit(paddr_i, OFF_STATUS)) begin
         rd_mux = status_r;
      end else if (reg_hit(paddr_i, OFF_INT_STAT)) begin
         rd_mux[INT_W-1:0] = int_stat_r;
      end else if (reg_hit(paddr_i, OFF_INT_MASK)) begin
         rd_mux[INT_W-1:0] = int_mask_r;
      end
   end

   // APB answer: one wait cycle for every access
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= RST_WORD;
      end else if (ce_i) begin
         pready_r  <= prep;
         pslverr_r <= prep & ~mapped;
         if (prep) begin
            prdata_r <= pwrite_i ? RST_WORD : rd_mux;
         end
      end
   end

   // Window command
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cmd_addr_r <= RST_WORD;
         dir_r      <= DIR_READ;
         size_r     <= RST_SIZE;
      end else if (acc_wr && reg_hit(paddr_i, OFF_CMD_ADDR)) begin
         cmd_addr_r <= pwdata_i;
      end else if (acc_wr && reg_hit(paddr_i, OFF_CMD_CTRL)) begin
         dir_r  <= pwdata_i[CTRL_DIR_BIT];
         size_r <= pwdata_i[CTRL_SIZE_LSB +: SIZE_W];
      end
   end

   // Block status: cleared by a new command, errors stick until then
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         status_r <= RST_WORD;
      end else if (ce_i) begin
         if (cmd_wr) begin
            status_r <= RST_WORD;
         end else begin
            status_r[ST_RANGE_BIT] <= status_r[ST_RANGE_BIT] | ap_err_range;            // RL10
            status_r[ST_DIR_BIT]   <= status_r[ST_DIR_BIT] | ap_err_dir;                // RL10
         end
         status_r[ST_PENDING_BIT] <= 1'b0;                                               // RL1
      end
   end

   // Interrupts: set wins over a clearing read
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         int_stat_r <= RST_INT;
         int_mask_r <= RST_INT;
         irq_r      <= 1'b0;
      end else if (ce_i) begin
         if (acc_rd && reg_hit(paddr_i, OFF_INT_STAT)) begin
            int_stat_r <= int_ev;
         end else begin
            int_stat_r <= int_stat_r | int_ev;
         end
         if (acc_wr && reg_hit(paddr_i, OFF_INT_MASK)) begin
            int_mask_r <= pwdata_i[INT_W-1:0];
         end
         irq_r <= |(int_stat_r & int_mask_r);
      end
   end

   assign prdata_o  = prdata_r;
   assign pready_o  = pready_r;
   assign pslverr_o = pslverr_r;
   assign irq_o     = irq_r;

   property p_pending_clear;
      @(posedge clk_i) disable iff (!resetn_i)
      (psel_i && !pwrite_i && pready_r && reg_hit(paddr_i, OFF_STATUS))
         |-> (prdata_r[ST_PENDING_BIT] == 1'b0) && (status_r[ST_PENDING_BIT] == 1'b0);
   endproperty
   a_pending_clear: assert property (p_pending_clear) else $error("pending bit set"); // RL1

   property p_drain_event;
      @(posedge clk_i) disable iff (!resetn_i)
      (acc_wr && reg_hit(paddr_i, OFF_FLUSH)) |=> int_stat_r[INT_DRAIN_BIT];
   endproperty
   a_drain_event: assert property (p_drain_event) else $error("flush hint not seen"); // RL7

   property p_range_error;
      @(posedge clk_i) disable iff (!resetn_i)
      (acc && aper_hit && !in_range) |=> status_r[ST_RANGE_BIT] && int_stat_r[INT_ERR_BIT];
   endproperty
   a_range_error: assert property (p_range_error) else $error("range error not reported"); // RL10

   property p_dir_error;
      @(posedge clk_i) disable iff (!resetn_i)
      (acc && aper_hit && (pwrite_i != dir_r) && !cmd_wr) |=> status_r[ST_DIR_BIT];
   endproperty
   a_dir_error: assert property (p_dir_error) else $error("direction error not reported"); // RL10

   property p_write_now;
      @(posedge clk_i) disable iff (!resetn_i)
      // Word must already sit in the media one cycle after the answer
      (acc_wr && aper_hit && in_range && dir_r == DIR_WRITE)
         |=> (u_media.mem_r[$past(mem_addr)] == $past(pwdata_i));
   endproperty
   a_write_now: assert property (p_write_now) else $error("aperture write deferred"); // RL12

   property p_map_addr;
      @(posedge clk_i) disable iff (!resetn_i)
      mem_we |-> (MEM_AW'(mem_addr - cmd_addr_r[MEM_AW+1:2]) == MEM_AW'(paddr_i[APER_IW+1:2]));
   endproperty
   a_map_addr: assert property (p_map_addr) else $error("media address mismatch"); // RL13

   property p_read_dir;
      @(posedge clk_i) disable iff (!resetn_i)
      (acc_rd && aper_hit && dir_r == DIR_WRITE) |-> (prdata_r == RST_WORD);
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("read allowed in write mode"); // RL13

endmodule

// *** rtl/media_store.sv ***
`timescale 1ns/100ps
module media_store
   import bwin_pkg::*;
(
   // Clock, reset and enable
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic              ce_i,
   // Access port
   input  wire logic              we_i,
   input  wire logic              re_i,
   input  wire logic [MEM_AW-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic      [DATA_W-1:0] rdata_o
);

   logic [DATA_W-1:0] mem_r [0:(1<<MEM_AW)-1];
   logic [DATA_W-1:0] rdata_r;

   // Writes land in the array at once, nothing is deferred
   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem_r[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_r <= RST_WORD;
      end else if (ce_i && re_i) begin
         rdata_r <= mem_r[addr_i];
      end
   end

   assign rdata_o = rdata_r;

endmodule
